//--- tlm_partner.sv
// quadrature encoder and limit sensor model for the monitor bench
`timescale 1ns/100ps
`default_nettype none
module tlm_partner (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fwd,
  input wire logic i_rev,
  input wire logic i_pos_act,
  input wire logic i_neg_act,
  input wire logic i_ls_nc,
  output logic o_enc_a,
  output logic o_enc_b,
  output logic o_pos_ls,
  output logic o_neg_ls
);
  logic [3:0] cnt;
  logic rev;
  logic ph_a;
  logic ph_b;
  // four cycles per quarter keeps each phase well past the input sync
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt <= 4'h0;
      rev <= 1'b0;
    end
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (i_fwd || i_rev)
    begin
      cnt <= 4'hF;
      rev <= i_rev;
    end
  end
  assign ph_a = cnt[3];
  assign ph_b = cnt[3] ^ cnt[2];
  // one full cycle per request; a leads b when forward
  assign o_enc_a = rev ? ph_b : ph_a;
  assign o_enc_b = rev ? ph_a : ph_b;
  assign o_pos_ls = i_pos_act ^ i_ls_nc;
  assign o_neg_ls = i_neg_act ^ i_ls_nc;
endmodule : tlm_partner
`default_nettype wire

//--- tlm_pkg.sv
// constants, types and register map for the travel limit and misstep monitor
`default_nettype none
package tlm_pkg;
  localparam int GEAR_W = 20;
  localparam int SETTLE_W = 27;
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_MS = 500;
  localparam int SETTLE_CYC = SETTLE_MS * CLK_MHZ * 1000;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LIM_POS = 4'h1;
  localparam logic [3:0] REG_LIM_NEG = 4'h2;
  localparam logic [3:0] REG_PRESET_POS = 4'h3;
  localparam logic [3:0] REG_ENC_PRESET = 4'h4;
  localparam logic [3:0] REG_BAND = 4'h5;
  localparam logic [3:0] REG_GEAR_A = 4'h6;
  localparam logic [3:0] REG_GEAR_B = 4'h7;
  localparam logic [3:0] REG_CMD_POS = 4'h8;
  localparam logic [3:0] REG_ENC_CNT = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'hA;
  localparam logic [3:0] REG_COMMAND = 4'hB;
  localparam int CMD_CLR_BIT = 0;
  localparam int CMD_ENC_PRE_BIT = 1;
  localparam logic [31:0] RST_LIM_POS = 32'h7FFFFFFF;
  localparam logic [31:0] RST_LIM_NEG = 32'h80000000;
  localparam logic [31:0] RST_BAND = 32'h0000000A;
  localparam logic [GEAR_W-1:0] RST_GEAR_A = 20'h001F4;
  localparam logic [GEAR_W-1:0] RST_GEAR_B = 20'h003E8;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_WARN = 2'h1;
  localparam logic [1:0] ACT_ALARM = 2'h2;
  localparam logic [2:0] ROUTE_OFF = 3'h7;
  typedef enum logic [1:0] {OP_IDLE, OP_POS, OP_CONT} op_e;
  typedef struct packed {
    logic [2:0] route;
    logic enc_present;
    logic ccw_pos;
    logic [1:0] act;
    logic ot_decel;
    logic ls_nc;
    logic misstep_en;
    logic sw_ot_en;
  } cfg_s;
  localparam cfg_s RST_CFG = '{route: ROUTE_OFF, enc_present: 1'b1,
    act: ACT_ALARM, default: 1'b0};
  typedef struct packed {
    logic [5:0] sy1;
    logic [5:0] sy2;
    logic [5:0] prev;
    cfg_s cfg;
    logic [31:0] lim_pos;
    logic [31:0] lim_neg;
    logic [31:0] preset_pos;
    logic [31:0] enc_preset;
    logic [31:0] band;
    logic [GEAR_W-1:0] gear_a;
    logic [GEAR_W-1:0] gear_b;
    logic [31:0] cmd_pos;
    logic [31:0] enc_cnt;
    op_e op;
    logic home_set;
    logic sw_alm;
    logic hw_alm;
    logic dev_alm;
    logic dev_warn;
    logic dev_err;
    logic [SETTLE_W-1:0] settle;
    logic stop;
    logic decel;
    logic slow;
    logic grant;
    logic [4:0] gp;
    logic a_valid;
    logic a_wr;
    logic [3:0] a_idx;
    logic [31:0] hrdata;
    logic hready;
  } state_s;
endpackage : tlm_pkg
`default_nettype wire

//--- travel_limit_misstep_monitor.sv
// travel limit, position counters and misstep monitor with AHB-Lite registers
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module travel_limit_misstep_monitor #(
  parameter int unsigned SETTLE_CYCLES = tlm_pkg::SETTLE_CYC
) (
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_POSITIVE_LIMIT_SENSOR,
  input wire logic I_NEGATIVE_LIMIT_SENSOR,
  input wire logic I_PRESET_IN,
  input wire logic I_ALARM_RESET_INPUT,
  input wire logic I_ENC_A,
  input wire logic I_ENC_B,
  input wire logic I_STEP_PULSE_OUTPUT,
  input wire logic I_STEP_DIR_NEG,
  input wire logic I_START_POS,
  input wire logic I_START_CONT,
  input wire logic I_CONT_DIR_NEG,
  input wire logic [31:0] I_TARGET_POS,
  input wire logic I_OP_DONE,
  input wire logic I_EXCITED,
  input wire logic I_MECH_HOMING,
  input wire logic I_HOME_DONE,
  output logic O_STOP,
  output logic O_DECEL,
  output logic O_SLOW_SPEED,
  output logic O_START_GRANT,
  output logic O_SW_OT_ALARM,
  output logic O_HW_OT_ALARM,
  output logic O_DEV_ALARM,
  output logic O_DEV_WARN,
  output logic [4:0] O_GENERAL_OUT
);
  import tlm_pkg::*;

  state_s r_reg;
  state_s r_next;
  logic lim_p;
  logic lim_n;
  logic lim_rise;
  logic sw_chk;
  logic cmd_clr;
  logic enc_pre;
  logic pre_rise;
  logic a_rise;
  logic rst_fall;
  logic follow;
  logic step_only;
  logic chk_en;
  logic dev_hit;
  logic toward;
  logic signed [63:0] cmd_sc;
  logic signed [63:0] enc_sc;
  logic signed [63:0] diff;
  logic signed [63:0] band_sc;

  localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(SETTLE_CYCLES);

  always_comb
  begin
    r_next = r_reg;
    // stage one of every synchroniser feeds only stage two
    r_next.sy1 = {I_ALARM_RESET_INPUT, I_ENC_B, I_ENC_A, I_PRESET_IN,
      I_NEGATIVE_LIMIT_SENSOR, I_POSITIVE_LIMIT_SENSOR};
    r_next.sy2 = r_reg.sy1;
    r_next.prev = r_reg.sy2;
    lim_p = r_reg.sy2[0] ^ r_reg.cfg.ls_nc;
    lim_n = r_reg.sy2[1] ^ r_reg.cfg.ls_nc;
    lim_rise = (lim_p & ~(r_reg.prev[0] ^ r_reg.cfg.ls_nc)) |
      (lim_n & ~(r_reg.prev[1] ^ r_reg.cfg.ls_nc));
    pre_rise = r_reg.sy2[2] & ~r_reg.prev[2];
    a_rise = r_reg.sy2[3] & ~r_reg.prev[3];
    // reset acts on the release edge of the input
    rst_fall = r_reg.prev[5] & ~r_reg.sy2[5];
    sw_chk = r_reg.cfg.sw_ot_en & r_reg.home_set;
    chk_en = r_reg.cfg.misstep_en & r_reg.cfg.enc_present & I_EXCITED &
      ~I_MECH_HOMING & (r_reg.settle == SETTLE_END);
    cmd_clr = 1'b0;
    enc_pre = 1'b0;

    // AHB-Lite: zero wait states, always OKAY
    r_next.hready = 1'b1;
    if (r_reg.a_valid && r_reg.a_wr)
    begin
      case (r_reg.a_idx)
        REG_CTRL: r_next.cfg = cfg_s'(I_HWDATA[$bits(cfg_s)-1:0]);
        REG_LIM_POS: r_next.lim_pos = I_HWDATA;
        REG_LIM_NEG: r_next.lim_neg = I_HWDATA;
        REG_PRESET_POS: r_next.preset_pos = I_HWDATA;
        REG_ENC_PRESET: r_next.enc_preset = I_HWDATA;
        REG_BAND: r_next.band = I_HWDATA;
        REG_GEAR_A: r_next.gear_a = I_HWDATA[GEAR_W-1:0];
        REG_GEAR_B: r_next.gear_b = I_HWDATA[GEAR_W-1:0];
        REG_COMMAND:
        begin
          cmd_clr = I_HWDATA[CMD_CLR_BIT];
          enc_pre = I_HWDATA[CMD_ENC_PRE_BIT];
        end
        default: ;
      endcase
    end
    r_next.a_valid = I_HSEL & I_HTRANS[1] & I_HREADY &
      (I_HADDR[31:6] == 26'h0000000);
    r_next.a_wr = I_HWRITE;
    r_next.a_idx = I_HADDR[5:2];
    r_next.hrdata = 32'h00000000;
    if (r_next.a_valid && !I_HWRITE)
    begin
      case (I_HADDR[5:2])
        REG_CTRL: r_next.hrdata = 32'(r_reg.cfg);
        REG_LIM_POS: r_next.hrdata = r_reg.lim_pos;
        REG_LIM_NEG: r_next.hrdata = r_reg.lim_neg;
        REG_PRESET_POS: r_next.hrdata = r_reg.preset_pos;
        REG_ENC_PRESET: r_next.hrdata = r_reg.enc_preset;
        REG_BAND: r_next.hrdata = r_reg.band;
        REG_GEAR_A: r_next.hrdata = 32'(r_reg.gear_a);
        REG_GEAR_B: r_next.hrdata = 32'(r_reg.gear_b);
        REG_CMD_POS: r_next.hrdata = r_reg.cmd_pos;
        REG_ENC_CNT: r_next.hrdata = r_reg.enc_cnt;
        REG_STATUS: r_next.hrdata = {22'h000000, r_reg.op, chk_en,
          r_reg.home_set, r_reg.dev_err, r_reg.dev_warn, r_reg.dev_alm,
          r_reg.hw_alm, r_reg.sw_alm, r_reg.stop};
        default: r_next.hrdata = 32'h00000000;
      endcase
    end

    // command position
    follow = r_reg.cfg.misstep_en & r_reg.cfg.enc_present & ~I_EXCITED;
    step_only = ~I_HOME_DONE & ~cmd_clr & ~pre_rise & ~follow;
    if (I_HOME_DONE || cmd_clr)
      r_next.cmd_pos = 32'h00000000;
    else if (pre_rise)
      r_next.cmd_pos = r_reg.preset_pos;
    else if (follow)
      r_next.cmd_pos = r_reg.enc_cnt;
    else if (I_STEP_PULSE_OUTPUT)
      r_next.cmd_pos = I_STEP_DIR_NEG ? r_reg.cmd_pos - 32'h00000001 :
        r_reg.cmd_pos + 32'h00000001;

    // encoder: one count per A rising edge, B gives direction
    if (I_HOME_DONE || cmd_clr)
      r_next.enc_cnt = 32'h00000000;
    else if (enc_pre)
      r_next.enc_cnt = r_reg.enc_preset;
    else if (a_rise)
      r_next.enc_cnt = (r_reg.sy2[4] ^ r_reg.cfg.ccw_pos) ?
        r_reg.enc_cnt - 32'h00000001 :
        r_reg.enc_cnt + 32'h00000001;

    if (I_HOME_DONE)
      r_next.home_set = 1'b1;

    // clear first so that a fresh alarm in the same cycle survives
    if (rst_fall)
    begin
      r_next.sw_alm = 1'b0;
      r_next.hw_alm = 1'b0;
      if (!r_reg.dev_err)
        r_next.dev_alm = 1'b0;
    end

    r_next.grant = 1'b0;
    toward = I_CONT_DIR_NEG ? lim_n : lim_p;
    case (r_reg.op)
      OP_IDLE:
      begin
        if (r_reg.stop)
          r_next.op = OP_IDLE;
        else if (I_START_POS)
        begin
          if (lim_p || lim_n)
            r_next.hw_alm = 1'b1;
          else if (sw_chk && ($signed(I_TARGET_POS) > $signed(r_reg.lim_pos)
              || $signed(I_TARGET_POS) < $signed(r_reg.lim_neg)))
            r_next.sw_alm = 1'b1;
          else
          begin
            r_next.grant = 1'b1;
            r_next.op = OP_POS;
          end
        end
        else if (I_START_CONT)
        begin
          if (toward)
            r_next.hw_alm = 1'b1;
          else if (sw_chk && (I_CONT_DIR_NEG ?
              $signed(r_reg.cmd_pos) <= $signed(r_reg.lim_neg) :
              $signed(r_reg.cmd_pos) >= $signed(r_reg.lim_pos)))
            r_next.sw_alm = 1'b1;
          else
          begin
            r_next.grant = 1'b1;
            r_next.op = OP_CONT;
          end
        end
      end
      OP_POS:
      begin
        if (lim_rise)
          r_next.hw_alm = 1'b1;
        if (I_OP_DONE || r_next.hw_alm || r_next.dev_alm)
          r_next.op = OP_IDLE;
      end
      OP_CONT:
      begin
        // the run checks the direction input as it is now, not as given at its start
        if (toward)
          r_next.hw_alm = 1'b1;
        else if (sw_chk && (I_CONT_DIR_NEG ?
            $signed(r_reg.cmd_pos) <= $signed(r_reg.lim_neg) :
            $signed(r_reg.cmd_pos) >= $signed(r_reg.lim_pos)))
          r_next.sw_alm = 1'b1;
        if (I_OP_DONE || r_next.hw_alm || r_next.sw_alm || r_next.dev_alm)
          r_next.op = OP_IDLE;
      end
      default: r_next.op = OP_IDLE;
    endcase
    r_next.slow = (r_next.op == OP_CONT) & (lim_p | lim_n);

    // deviation check, gears used only here
    if (!I_EXCITED || I_MECH_HOMING)
      r_next.settle = '0;
    else if (r_reg.settle != SETTLE_END)
      r_next.settle = r_reg.settle + 1'b1;
    cmd_sc = $signed({{32{r_reg.cmd_pos[31]}}, r_reg.cmd_pos}) *
      $signed({{(64-GEAR_W){1'b0}}, r_reg.gear_a});
    enc_sc = $signed({{32{r_reg.enc_cnt[31]}}, r_reg.enc_cnt}) *
      $signed({{(64-GEAR_W){1'b0}}, r_reg.gear_b});
    diff = cmd_sc - enc_sc;
    if (diff < 0)
      diff = -diff;
    band_sc = $signed({32'h00000000, r_reg.band}) *
      $signed({{(64-GEAR_W){1'b0}}, r_reg.gear_a});
    // a difference taken from counters being zeroed by the clear command now is void
    dev_hit = chk_en & ~cmd_clr & (diff >= band_sc);
    if (!I_EXCITED || I_MECH_HOMING || cmd_clr)
      r_next.dev_err = 1'b0;
    if (dev_hit)
      r_next.dev_err = 1'b1;
    if (dev_hit && r_reg.cfg.act == ACT_ALARM)
      r_next.dev_alm = 1'b1;
    r_next.dev_warn = r_next.dev_err & (r_reg.cfg.act == ACT_WARN);
    for (int i = 0; i < 5; i++)
      r_next.gp[i] = r_next.dev_err & (r_reg.cfg.route == 3'(i));

    r_next.stop = r_next.sw_alm | r_next.hw_alm | r_next.dev_alm;
    r_next.decel = r_next.sw_alm |
      (r_next.hw_alm & r_reg.cfg.ot_decel);
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_SYS_RST)
    begin
      r_reg <= '0;
      r_reg.cfg <= RST_CFG;
      r_reg.lim_pos <= RST_LIM_POS;
      r_reg.lim_neg <= RST_LIM_NEG;
      r_reg.band <= RST_BAND;
      r_reg.gear_a <= RST_GEAR_A;
      r_reg.gear_b <= RST_GEAR_B;
      r_reg.op <= OP_IDLE;
      r_reg.hready <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign O_HRDATA = r_reg.hrdata;
  assign O_HREADYOUT = r_reg.hready;
  assign O_HRESP = 1'b0;
  assign O_STOP = r_reg.stop;
  assign O_DECEL = r_reg.decel;
  assign O_SLOW_SPEED = r_reg.slow;
  assign O_START_GRANT = r_reg.grant;
  assign O_SW_OT_ALARM = r_reg.sw_alm;
  assign O_HW_OT_ALARM = r_reg.hw_alm;
  assign O_DEV_ALARM = r_reg.dev_alm;
  assign O_DEV_WARN = r_reg.dev_warn;
  assign O_GENERAL_OUT = r_reg.gp;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  property p_sw_off;
    !r_reg.sw_alm && !r_reg.cfg.sw_ot_en |=> !r_reg.sw_alm;
  endproperty
  a_sw_off: assert property (p_sw_off)
    else $error("soft alarm raised while soft limits disabled");

  property p_sw_nohome;
    !r_reg.sw_alm && !r_reg.home_set |=> !r_reg.sw_alm;
  endproperty
  a_sw_nohome: assert property (p_sw_nohome)
    else $error("soft alarm raised before home was set");

  property p_pos_block;
    r_reg.op == OP_IDLE && !r_reg.stop && I_START_POS && (lim_p || lim_n)
      |=> r_reg.hw_alm && !r_reg.grant && r_reg.op == OP_IDLE;
  endproperty
  a_pos_block: assert property (p_pos_block)
    else $error("positioning started with a limit active");

  property p_home;
    I_HOME_DONE |=> r_reg.cmd_pos == 32'h0 && r_reg.enc_cnt == 32'h0;
  endproperty
  a_home: assert property (p_home)
    else $error("home completion did not clear counters");

  property p_step;
    I_STEP_PULSE_OUTPUT && !I_STEP_DIR_NEG && step_only
      |=> r_reg.cmd_pos == $past(r_reg.cmd_pos) + 32'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("forward step did not increment command position");

  property p_settle;
    $rose(r_reg.dev_err) |-> $past(r_reg.settle) == SETTLE_END;
  endproperty
  a_settle: assert property (p_settle)
    else $error("deviation flagged before settle time");

  property p_unexcite;
    !I_EXCITED |=> !r_reg.dev_err ##1 !r_reg.dev_warn || I_EXCITED;
  endproperty
  a_unexcite: assert property (p_unexcite)
    else $error("deviation error held while unexcited");

  property p_dev_hold;
    r_reg.dev_alm && r_reg.dev_err && rst_fall |=> r_reg.dev_alm;
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("deviation alarm reset while error still present");

  property p_hw_stop;
    $rose(r_reg.hw_alm) |-> r_reg.stop && r_reg.op == OP_IDLE &&
      !r_reg.grant;
  endproperty
  a_hw_stop: assert property (p_hw_stop)
    else $error("hard overtravel did not stop the motion");
endmodule : travel_limit_misstep_monitor
`default_nettype wire

//--- travel_limit_misstep_monitor_tb.sv
// register and pin level tests of the travel limit and misstep monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  err_count++; $display("mismatch %s exp %h seen %h", nm, ex, gt); end end
module travel_limit_misstep_monitor_tb;
  import tlm_pkg::*;
  int err_count = 0, checks = 0;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, target = 32'h0, rdv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic preset = 1'b0, arst = 1'b0, stp = 1'b0, sdir = 1'b0, done = 1'b0;
  logic st_pos = 1'b0, st_cont = 1'b0, cdir = 1'b0, exc = 1'b0;
  logic hdone = 1'b0, fwd = 1'b0, rev = 1'b0, pact = 1'b0, nact = 1'b0;
  logic nc = 1'b0, mh = 1'b0;
  wire logic hready, hresp, enc_a, enc_b, pls, nls, stop, decel, slow;
  wire logic grant, swa, hwa, dva, dvw;
  wire logic [31:0] hrdata;
  wire logic [4:0] gout;
  always #2.5 clk = ~clk;
  travel_limit_misstep_monitor #(.SETTLE_CYCLES(40))
    i_travel_limit_misstep_monitor (.I_SYS_CLK(clk), .I_SYS_RST(rst),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_POSITIVE_LIMIT_SENSOR(pls), .I_NEGATIVE_LIMIT_SENSOR(nls),
    .I_PRESET_IN(preset), .I_ALARM_RESET_INPUT(arst), .I_ENC_A(enc_a),
    .I_ENC_B(enc_b), .I_STEP_PULSE_OUTPUT(stp), .I_STEP_DIR_NEG(sdir),
    .I_START_POS(st_pos), .I_START_CONT(st_cont), .I_CONT_DIR_NEG(cdir),
    .I_TARGET_POS(target), .I_OP_DONE(done), .I_EXCITED(exc),
    .I_MECH_HOMING(mh), .I_HOME_DONE(hdone), .O_STOP(stop),
    .O_DECEL(decel), .O_SLOW_SPEED(slow), .O_START_GRANT(grant),
    .O_SW_OT_ALARM(swa), .O_HW_OT_ALARM(hwa), .O_DEV_ALARM(dva),
    .O_DEV_WARN(dvw), .O_GENERAL_OUT(gout));
  tlm_partner i_tlm_partner (.i_clk(clk), .i_rst(rst), .i_fwd(fwd),
    .i_rev(rev), .i_pos_act(pact), .i_neg_act(nact), .i_ls_nc(nc),
    .o_enc_a(enc_a), .o_enc_b(enc_b), .o_pos_ls(pls), .o_neg_ls(nls));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one single AHB-Lite transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [3:0] idx,
    input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {26'h0, idx, 2'b00};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : bus

  task automatic rd(input string nm, input logic [3:0] idx,
    input logic [31:0] ex);
    bus(1'b0, idx, 32'h0);
    `CHK(nm, ex, rdv)
  endtask : rd

  function automatic logic [31:0] cfgw(input logic [2:0] rt,
    input logic ccw, input logic [1:0] act, input logic [3:0] low);
    // low holds decel, contact, misstep enable, soft limit enable
    return {21'h0, rt, 1'b1, ccw, act, low};
  endfunction : cfgw

  task automatic start(input logic cont, input logic neg,
    input logic [31:0] tgt, input logic ex);
    st_pos <= ~cont;
    st_cont <= cont;
    cdir <= neg;
    target <= tgt;
    tick(1);
    st_pos <= 1'b0;
    st_cont <= 1'b0;
    tick(1);
    `CHK("grant", ex, grant)
  endtask : start

  task automatic op_end();
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(2);
  endtask : op_end

  task automatic alm_reset();
    arst <= 1'b1;
    tick(4);
    arst <= 1'b0;
    tick(6);
  endtask : alm_reset

  task automatic steps(input int n, input logic neg);
    repeat (n)
    begin
      stp <= 1'b1;
      sdir <= neg;
      tick(1);
      stp <= 1'b0;
      tick(1);
    end
    tick(3);
  endtask : steps

  // the encoder model needs 16 cycles per cycle plus sync delay
  task automatic enc(input int n, input logic r);
    repeat (n)
    begin
      fwd <= ~r;
      rev <= r;
      tick(1);
      fwd <= 1'b0;
      rev <= 1'b0;
      tick(22);
    end
  endtask : enc

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    #100000;
    err_count++;
    summarize();
  end

  initial
  begin
    tick(2);
    rst <= 1'b0;
    tick(1);
    rd("ctrl", REG_CTRL, 32'h000007A0);
    rd("lim_pos", REG_LIM_POS, RST_LIM_POS);
    rd("lim_neg", REG_LIM_NEG, RST_LIM_NEG);
    rd("band", REG_BAND, RST_BAND);
    rd("gear_a", REG_GEAR_A, 32'(RST_GEAR_A));
    rd("gear_b", REG_GEAR_B, 32'(RST_GEAR_B));
    bus(1'b1, REG_CMD_POS, 32'h00000055);
    rd("cmd_ro", REG_CMD_POS, 32'h0);
    rd("unmapped", 4'hC, 32'h0);
    `CHK("hresp", 1'b0, hresp)
    steps(3, 1'b0);
    steps(1, 1'b1);
    rd("cmd_pos", REG_CMD_POS, 32'h2);
    enc(3, 1'b0);
    enc(1, 1'b1);
    rd("enc_cnt", REG_ENC_CNT, 32'h2);
    rd("cmd_keep", REG_CMD_POS, 32'h2);
    bus(1'b1, REG_CTRL, cfgw(ROUTE_OFF, 1'b1, ACT_ALARM, 4'h0));
    enc(1, 1'b0);
    rd("enc_ccw", REG_ENC_CNT, 32'h1);
    bus(1'b1, REG_ENC_PRESET, 32'h12345678);
    bus(1'b1, REG_COMMAND, 32'h2);
    rd("enc_pre", REG_ENC_CNT, 32'h12345678);
    bus(1'b1, REG_CTRL, cfgw(ROUTE_OFF, 1'b0, ACT_ALARM, 4'h1));
    bus(1'b1, REG_LIM_POS, 32'd1000);
    start(1'b0, 1'b0, 32'd2000, 1'b1);
    op_end();
    hdone <= 1'b1;
    tick(1);
    hdone <= 1'b0;
    tick(2);
    rd("home_cmd", REG_CMD_POS, 32'h0);
    rd("home_enc", REG_ENC_CNT, 32'h0);
    start(1'b0, 1'b0, 32'd2000, 1'b0);
    tick(1);
    `CHK("sw_alarm", 1'b1, swa)
    `CHK("sw_decel", 1'b1, decel)
    `CHK("sw_stop", 1'b1, stop)
    alm_reset();
    `CHK("sw_clear", 1'b0, swa)
    bus(1'b1, REG_CTRL, cfgw(ROUTE_OFF, 1'b0, ACT_ALARM, 4'h0));
    start(1'b0, 1'b0, 32'd2000, 1'b1);
    tick(1);
    `CHK("sw_off", 1'b0, swa)
    op_end();
    steps(2, 1'b0);
    enc(1, 1'b0);
    bus(1'b1, REG_COMMAND, 32'h1);
    rd("clr_cmd", REG_CMD_POS, 32'h0);
    rd("clr_enc", REG_ENC_CNT, 32'h0);
    bus(1'b1, REG_PRESET_POS, 32'h7FFFFFFF);
    preset <= 1'b1;
    tick(6);
    preset <= 1'b0;
    tick(2);
    rd("preset", REG_CMD_POS, 32'h7FFFFFFF);
    steps(1, 1'b0);
    rd("cmd_max", REG_CMD_POS, 32'h80000000);
    steps(1, 1'b1);
    rd("cmd_min", REG_CMD_POS, 32'h7FFFFFFF);
    start(1'b0, 1'b0, 32'd100, 1'b1);
    pact <= 1'b1;
    tick(6);
    `CHK("hw_run", 1'b1, hwa)
    `CHK("hw_stop", 1'b1, stop)
    `CHK("hw_decel", 1'b0, decel)
    pact <= 1'b0;
    alm_reset();
    nc <= 1'b1;
    bus(1'b1, REG_CTRL, cfgw(ROUTE_OFF, 1'b0, ACT_ALARM, 4'hC));
    pact <= 1'b1;
    tick(6);
    start(1'b0, 1'b0, 32'd100, 1'b0);
    tick(1);
    `CHK("hw_start", 1'b1, hwa)
    `CHK("hw_decel_on", 1'b1, decel)
    alm_reset();
    start(1'b1, 1'b1, 32'h0, 1'b1);
    tick(1);
    `CHK("slow_in", 1'b1, slow)
    pact <= 1'b0;
    tick(6);
    `CHK("slow_out", 1'b0, slow)
    op_end();
    bus(1'b1, REG_GEAR_B, 32'd500);
    bus(1'b1, REG_COMMAND, 32'h1);
    bus(1'b1, REG_CTRL, cfgw(3'h2, 1'b0, ACT_ALARM, 4'h6));
    exc <= 1'b1;
    steps(12, 1'b0);
    `CHK("settle", 1'b0, dva)
    tick(30);
    `CHK("dev_alarm", 1'b1, dva)
    `CHK("gen_out", 5'h04, gout)
    `CHK("dev_stop", 1'b1, stop)
    alm_reset();
    `CHK("dev_hold", 1'b1, dva)
    exc <= 1'b0;
    tick(4);
    `CHK("gen_clr", 5'h00, gout)
    alm_reset();
    `CHK("dev_rst", 1'b0, dva)
    enc(2, 1'b0);
    rd("follow", REG_CMD_POS, 32'h2);
    bus(1'b1, REG_CTRL, cfgw(3'h0, 1'b0, ACT_WARN, 4'h6));
    exc <= 1'b1;
    tick(50);
    steps(9, 1'b0);
    `CHK("warn_low", 1'b0, dvw)
    steps(1, 1'b0);
    `CHK("warn", 1'b1, dvw)
    `CHK("warn_out", 5'h01, gout)
    `CHK("warn_alm", 1'b0, dva)
    bus(1'b1, REG_COMMAND, 32'h1);
    tick(2);
    `CHK("warn_clr", 1'b0, dvw)
    steps(10, 1'b0);
    `CHK("warn_again", 1'b1, dvw)
    mh <= 1'b1;
    steps(2, 1'b0);
    `CHK("mh_clr", 1'b0, dvw)
    mh <= 1'b0;
    tick(20);
    `CHK("mh_settle", 1'b0, dvw)
    bus(1'b1, REG_CTRL, cfgw(3'h1, 1'b0, ACT_NONE, 4'h6));
    tick(50);
    `CHK("none_out", 5'h02, gout)
    `CHK("none_warn", 1'b0, dvw)
    `CHK("none_alm", 1'b0, dva)
    exc <= 1'b0;
    tick(2);
    summarize();
  end
endmodule : travel_limit_misstep_monitor_tb
`default_nettype wire
